// ==== core/mbr_pkg.sv ====
// Shared constants and types for the memory bus reference port
package mbr_pkg;
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_WREG5 = 8'h14;
    localparam logic [7:0] OFS_RD_WORK = 8'h18;
    localparam logic [7:0] OFS_RD_LOCAL = 8'h1C;
    localparam int MODE_LEGACY = 0;
    localparam int MODE_PRIV_LSB = 1;
    localparam int CMD_FUNC_LSB = 0;
    localparam int CMD_SIZE_LSB = 5;
    localparam int CMD_KIND_LSB = 7;
    localparam int CMD_XFER = 9;
    localparam int CMD_DSEL_LSB = 10;
    localparam int STB_IDLE = 0;
    localparam int STB_BEATS_LSB = 1;
    localparam int STB_FAULT = 4;
    localparam int STB_SIZE_LSB = 5;
    localparam int STB_REJECT = 7;
    localparam int STB_LOADIB = 8;
    localparam int STB_GRANT = 9;
    localparam int STB_BUSY = 10;
    localparam logic [31:0] REG_ZERO = 32'h0000_0000;
    localparam logic [31:0] CMD_RESET = 32'h0000_0008;
    localparam logic [4:0] FUNC_READ_VIRT = 5'h08;
    localparam logic [2:0] DSEL_READ_WORK = 3'h0;
    localparam logic [2:0] DSEL_WRITE = 3'h1;
    localparam logic [2:0] DSEL_READ_LOCAL = 3'h4;
    localparam logic [2:0] BEATS_NONE = 3'h0;
    localparam logic [2:0] BEATS_ONE = 3'h1;
    localparam logic [2:0] BEATS_QUAD = 3'h2;
    localparam logic [2:0] BEATS_OCTA = 3'h4;
    localparam logic [1:0] GAP_FIRST = 2'h1;
    localparam logic [1:0] GAP_LAST = 2'h3;
    localparam logic [2:0] LANES_ALL = 3'h7;
    localparam logic [2:0] LANES_WORD = 3'h3;
    localparam logic [2:0] LANES_BYTE = 3'h1;
    localparam logic [2:0] LANES_OFF = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {SIZE_BYTE = 2'h0, SIZE_WORD = 2'h1, SIZE_BAD = 2'h2, SIZE_LONG = 2'h3} mbr_size_type;
    typedef enum logic [1:0] {KIND_SINGLE = 2'h0, KIND_QUAD = 2'h1, KIND_OCTA = 2'h2,
                              KIND_PREFETCH = 2'h3} mbr_kind_type;
    typedef enum logic [2:0] {S_IDLE = 3'h0, S_REQ_WAIT = 3'h1, S_REQ_DONE = 3'h3, S_GAP = 3'h2,
                              S_XFER_WAIT = 3'h6, S_XFER_DONE = 3'h7} mbr_state_type;
endpackage : mbr_pkg

// ==== core/mbr_port.sv ====
// Memory bus reference port: CPU end of the memory control bus with AXI4-Lite control
// Behaviour
// RULE1: One request then one transfer per longword; quadword two, octaword four.
// RULE2: Prefetch refill issues the request only; controller loads buffer itself.
// RULE3: Octaword reads and writes allowed; quadword only as read.
// RULE4: Request raises memory request, size lines, type bit one, five function bits.
// RULE5: Function code 01000 means read of a virtual address.
// RULE6: Size lines carry byte, word or longword from the request size field.
// RULE7: Each request drives legacy mode flag and two-bit privilege level.
// RULE8: Controller refuses unaligned words in legacy mode and applies protection.
// RULE9: Request drives the full 32-bit address from local store onto the bus.
// RULE10: Grant accepts the address; without grant phase two stalls.
// RULE11: On grant store address in working register 5 and latch size.
// RULE12: Controller holds busy while it processes the request.
// RULE13: One unrelated microinstruction separates request and first transfer.
// RULE14: Datapath select 1 writes, 0 reads to working register, 4 to local store.
// RULE15: Transfer raises data request; writes drive all 32 data bits.
// RULE16: Three lane enables; all on for address and write data.
// RULE17: Read lanes gated by latched size; disabled upper lanes get sign extension.
// RULE18: Controller sets bus direction toward memory, reverses it after read request.
// RULE19: Write completes when busy drops; CPU asserts transfer done.
// RULE20: Read data valid when busy drops; CPU captures it and asserts transfer done.
// RULE21: Busy during a transfer stalls phase two until busy falls.
// RULE22: Fault summary ends the stall and is offered as a skip condition; here only busy falling ends the stall, and the fault is sampled then.
// RULE23: Reset holds request, data request, transfer done low and size cleared.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mbr_port (
    input wire logic clk, // 200 MHz
    input wire logic rst, // Async, active high
    input wire logic [7:0] awaddr, // AXI write address
    input wire logic awvalid, // AXI
    output logic awready, // AXI
    input wire logic [31:0] wdata, // AXI write data
    input wire logic [3:0] wstrb, // AXI byte strobes
    input wire logic wvalid, // AXI
    output logic wready, // AXI
    output logic [1:0] bresp, // AXI
    output logic bvalid, // AXI
    input wire logic bready, // AXI
    input wire logic [7:0] araddr, // AXI read address
    input wire logic arvalid, // AXI
    output logic arready, // AXI
    output logic [31:0] rdata, // AXI read data
    output logic [1:0] rresp, // AXI
    output logic rvalid, // AXI
    input wire logic rready, // AXI
    input wire logic grantIn, // Controller grant
    input wire logic busyIn, // Controller busy
    input wire logic faultSummaryIn, // Controller error summary
    input wire logic gateDirIn, // High: toward memory bus
    input wire logic loadInstrBufferIn, // Controller prefetch load strobe
    input wire logic [31:0] dataIn, // Bus data in
    output logic [31:0] dataOut, // Bus data out
    output logic dataOe_n, // Low while driving
    output logic memReq, // Memory cycle request
    output logic reqTypeBit, // Request-type bit
    output logic [1:0] sizeLines, // Transfer size
    output logic [4:0] funcCode, // Memory function
    output logic legacyModeFlag, // Legacy mode
    output logic [1:0] privilegeLevel, // Current privilege
    output logic dataReq, // Data request
    output logic transferDone, // Data received
    output logic upperHalfEnable, // Lanes 31:16
    output logic byte1LaneEnable, // Lanes 15:8
    output logic byte0LaneEnable, // Lanes 7:0
    output logic faultSkip // Sticky error skip condition
);
    function automatic logic [2:0] laneEnables(input logic drive, input logic rd, input logic [1:0] size);
        logic [2:0] l;
        l = mbr_pkg::LANES_OFF;
        if (drive) begin
            l = mbr_pkg::LANES_ALL;
        end else if (rd) begin
            case (size)
                mbr_pkg::SIZE_BYTE: l = mbr_pkg::LANES_BYTE;
                mbr_pkg::SIZE_WORD: l = mbr_pkg::LANES_WORD;
                default: l = mbr_pkg::LANES_ALL;
            endcase
        end
        return l;
    endfunction : laneEnables
    function automatic logic [31:0] signExtend(input logic [31:0] d, input logic [1:0] size);
        logic [31:0] v;
        v = d;
        if (size == mbr_pkg::SIZE_BYTE) begin
            v = {{24{d[7]}}, d[7:0]};
        end else if (size == mbr_pkg::SIZE_WORD) begin
            v = {{16{d[15]}}, d[15:0]};
        end
        return v;
    endfunction : signExtend
    function automatic logic [31:0] applyStrobe(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                v[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return v;
    endfunction : applyStrobe
    function automatic logic isMapped(input logic [7:0] a);
        return a == mbr_pkg::OFS_MODE || a == mbr_pkg::OFS_ADDR || a == mbr_pkg::OFS_WDATA
            || a == mbr_pkg::OFS_CMD || a == mbr_pkg::OFS_STATUS || a == mbr_pkg::OFS_WREG5
            || a == mbr_pkg::OFS_RD_WORK || a == mbr_pkg::OFS_RD_LOCAL;
    endfunction : isMapped
    // Bus pins are asynchronous to clk
    logic [4:0] pinMeta_r, pinSync_r;
    logic [31:0] dataMeta_r, dataSync_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinMeta_r <= '0;
            pinSync_r <= '0;
            dataMeta_r <= mbr_pkg::REG_ZERO;
            dataSync_r <= mbr_pkg::REG_ZERO;
        end else begin
            pinMeta_r <= {loadInstrBufferIn, gateDirIn, faultSummaryIn, busyIn, grantIn};
            pinSync_r <= pinMeta_r;
            dataMeta_r <= dataIn;
            dataSync_r <= dataMeta_r;
        end
    end
    logic grantSync, busySync, faultSync, dirSync, loadIbSync;
    assign {loadIbSync, dirSync, faultSync, busySync, grantSync} = pinSync_r;
    // AXI4-Lite slave; address and data may arrive in either order
    logic [7:0] awaddr_r;
    logic [31:0] wdat_r;
    logic [3:0] wstrb_r;
    logic wrGo;
    assign wrGo = !awready && !wready && !bvalid;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= mbr_pkg::RESP_OKAY;
            awaddr_r <= '0;
            wdat_r <= mbr_pkg::REG_ZERO;
            wstrb_r <= '0;
        end else begin
            if (awvalid && awready) begin
                awaddr_r <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wdat_r <= wdata;
                wstrb_r <= wstrb;
                wready <= 1'b0;
            end
            if (wrGo) begin
                bvalid <= 1'b1;
                bresp <= isMapped(awaddr_r) ? mbr_pkg::RESP_OKAY : mbr_pkg::RESP_SLVERR;
                awready <= 1'b1;
                wready <= 1'b1;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    mbr_pkg::mbr_state_type state_r, stateNxt;
    logic [31:0] mode_r, addrReg_r, wdataReg_r, cmd_r, workReg5_r, rdWork_r, rdLocal_r;
    logic cmdPulse_r, reject_r, quadRef_r;
    logic [2:0] beatsLeft_r;
    logic [1:0] gapCnt_r, latchedSize_r;
    logic wrCmd, wrStatus;
    assign wrCmd = wrGo && awaddr_r == mbr_pkg::OFS_CMD;
    assign wrStatus = wrGo && awaddr_r == mbr_pkg::OFS_STATUS && wstrb_r[0];
    // Command only stored while idle, so fields stay put for the whole request or transfer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= mbr_pkg::REG_ZERO;
            addrReg_r <= mbr_pkg::REG_ZERO;
            wdataReg_r <= mbr_pkg::REG_ZERO;
            cmd_r <= mbr_pkg::CMD_RESET; // RULE5
            cmdPulse_r <= 1'b0;
        end else begin
            cmdPulse_r <= wrCmd && state_r == mbr_pkg::S_IDLE;
            if (wrGo && awaddr_r == mbr_pkg::OFS_MODE) begin
                mode_r <= applyStrobe(mode_r, wdat_r, wstrb_r);
            end
            if (wrGo && awaddr_r == mbr_pkg::OFS_ADDR) begin
                addrReg_r <= applyStrobe(addrReg_r, wdat_r, wstrb_r);
            end
            if (wrGo && awaddr_r == mbr_pkg::OFS_WDATA) begin
                wdataReg_r <= applyStrobe(wdataReg_r, wdat_r, wstrb_r);
            end
            if (wrCmd && state_r == mbr_pkg::S_IDLE) begin
                cmd_r <= applyStrobe(cmd_r, wdat_r, wstrb_r);
            end
        end
    end
    assign legacyModeFlag = mode_r[mbr_pkg::MODE_LEGACY]; // RULE7
    assign privilegeLevel = mode_r[mbr_pkg::MODE_PRIV_LSB +: 2]; // RULE7
    logic [4:0] cmdFunc;
    logic [1:0] cmdSize, cmdKind;
    logic [2:0] cmdDsel;
    logic cmdIsXfer, cmdRead, cmdOk;
    assign cmdFunc = cmd_r[mbr_pkg::CMD_FUNC_LSB +: 5];
    assign cmdSize = cmd_r[mbr_pkg::CMD_SIZE_LSB +: 2];
    assign cmdKind = cmd_r[mbr_pkg::CMD_KIND_LSB +: 2];
    assign cmdIsXfer = cmd_r[mbr_pkg::CMD_XFER];
    assign cmdDsel = cmd_r[mbr_pkg::CMD_DSEL_LSB +: 3];
    assign cmdRead = cmdDsel == mbr_pkg::DSEL_READ_WORK || cmdDsel == mbr_pkg::DSEL_READ_LOCAL; // RULE14
    // Transfers need an open reference; a new request needs the last one finished
    assign cmdOk = cmdIsXfer
        ? (beatsLeft_r != mbr_pkg::BEATS_NONE
           && (cmdRead || (cmdDsel == mbr_pkg::DSEL_WRITE && !quadRef_r))) // RULE1 RULE3 RULE14
        : (beatsLeft_r == mbr_pkg::BEATS_NONE && cmdSize != mbr_pkg::SIZE_BAD); // RULE1
    always_comb begin
        stateNxt = state_r;
        case (state_r)
            mbr_pkg::S_IDLE: begin
                if (cmdPulse_r && cmdOk) begin
                    stateNxt = cmdIsXfer ? mbr_pkg::S_XFER_WAIT : mbr_pkg::S_REQ_WAIT;
                end
            end
            mbr_pkg::S_REQ_WAIT: if (grantSync) stateNxt = mbr_pkg::S_REQ_DONE; // RULE10
            mbr_pkg::S_REQ_DONE: stateNxt = mbr_pkg::S_GAP;
            mbr_pkg::S_GAP: if (gapCnt_r == mbr_pkg::GAP_LAST) stateNxt = mbr_pkg::S_IDLE; // RULE13
            mbr_pkg::S_XFER_WAIT: if (!busySync) stateNxt = mbr_pkg::S_XFER_DONE; // RULE21 RULE12
            mbr_pkg::S_XFER_DONE: stateNxt = mbr_pkg::S_IDLE;
            default: stateNxt = mbr_pkg::S_IDLE;
        endcase
    end
    logic xferEnd;
    assign xferEnd = state_r == mbr_pkg::S_XFER_WAIT && !busySync;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= mbr_pkg::S_IDLE;
            gapCnt_r <= mbr_pkg::GAP_FIRST;
            beatsLeft_r <= mbr_pkg::BEATS_NONE;
            quadRef_r <= 1'b0;
            latchedSize_r <= mbr_pkg::SIZE_BYTE; // RULE23
            workReg5_r <= mbr_pkg::REG_ZERO;
        end else begin
            state_r <= stateNxt;
            gapCnt_r <= (state_r == mbr_pkg::S_GAP) ? gapCnt_r + 2'h1 : mbr_pkg::GAP_FIRST;
            if (state_r == mbr_pkg::S_REQ_DONE) begin
                workReg5_r <= addrReg_r; // RULE11
                latchedSize_r <= sizeLines; // RULE11
                quadRef_r <= cmdKind == mbr_pkg::KIND_QUAD;
                case (cmdKind)
                    mbr_pkg::KIND_QUAD: beatsLeft_r <= mbr_pkg::BEATS_QUAD; // RULE1
                    mbr_pkg::KIND_OCTA: beatsLeft_r <= mbr_pkg::BEATS_OCTA; // RULE1
                    mbr_pkg::KIND_PREFETCH: beatsLeft_r <= mbr_pkg::BEATS_NONE; // RULE2
                    default: beatsLeft_r <= mbr_pkg::BEATS_ONE;
                endcase
            end else if (state_r == mbr_pkg::S_XFER_DONE) begin
                // A fault abandons the rest of the reference
                beatsLeft_r <= faultSkip ? mbr_pkg::BEATS_NONE : beatsLeft_r - 3'h1; // RULE22
            end
        end
    end
    // Read capture with sign extension into the chosen destination
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdWork_r <= mbr_pkg::REG_ZERO;
            rdLocal_r <= mbr_pkg::REG_ZERO;
        end else if (xferEnd && cmdRead) begin
            if (cmdDsel == mbr_pkg::DSEL_READ_WORK) begin
                rdWork_r <= signExtend(dataSync_r, latchedSize_r); // RULE20 RULE14 RULE17
            end else begin
                rdLocal_r <= signExtend(dataSync_r, latchedSize_r); // RULE20 RULE14 RULE17
            end
        end
    end
    // Sticky flags: a hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            faultSkip <= 1'b0;
            reject_r <= 1'b0;
        end else begin
            if (xferEnd && faultSync) begin
                faultSkip <= 1'b1; // RULE22
            end else if (wrStatus && wdat_r[mbr_pkg::STB_FAULT]) begin
                faultSkip <= 1'b0;
            end
            if ((cmdPulse_r && !cmdOk) || (wrCmd && state_r != mbr_pkg::S_IDLE)) begin
                reject_r <= 1'b1;
            end else if (wrStatus && wdat_r[mbr_pkg::STB_REJECT]) begin
                reject_r <= 1'b0;
            end
        end
    end
    // Bus outputs registered from next state, so they change with the phase
    logic reqPhase, writePhase, readPhase;
    assign reqPhase = stateNxt == mbr_pkg::S_REQ_WAIT || stateNxt == mbr_pkg::S_REQ_DONE;
    assign writePhase = (stateNxt == mbr_pkg::S_XFER_WAIT || stateNxt == mbr_pkg::S_XFER_DONE) && !cmdRead;
    assign readPhase = (stateNxt == mbr_pkg::S_XFER_WAIT || stateNxt == mbr_pkg::S_XFER_DONE) && cmdRead;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            memReq <= 1'b0; // RULE23
            reqTypeBit <= 1'b0;
            dataReq <= 1'b0; // RULE23
            transferDone <= 1'b0; // RULE23
            sizeLines <= mbr_pkg::SIZE_BYTE;
            funcCode <= '0;
            dataOut <= mbr_pkg::REG_ZERO;
            dataOe_n <= 1'b1;
            {upperHalfEnable, byte1LaneEnable, byte0LaneEnable} <= mbr_pkg::LANES_OFF;
        end else begin
            memReq <= stateNxt == mbr_pkg::S_REQ_WAIT; // RULE4
            reqTypeBit <= stateNxt == mbr_pkg::S_REQ_WAIT; // RULE4
            if (state_r == mbr_pkg::S_IDLE && stateNxt == mbr_pkg::S_REQ_WAIT) begin
                funcCode <= cmdFunc; // RULE4
                // Multi-longword references always move full longwords
                sizeLines <= (cmdKind == mbr_pkg::KIND_QUAD || cmdKind == mbr_pkg::KIND_OCTA)
                    ? mbr_pkg::SIZE_LONG : cmdSize; // RULE6
            end
            dataReq <= stateNxt == mbr_pkg::S_XFER_WAIT; // RULE15
            transferDone <= stateNxt == mbr_pkg::S_XFER_DONE; // RULE19 RULE20
            dataOut <= reqPhase ? addrReg_r : wdataReg_r; // RULE9 RULE15
            // Never fight the controller once it turns the bus round
            dataOe_n <= !((reqPhase || writePhase) && dirSync); // RULE18
            {upperHalfEnable, byte1LaneEnable, byte0LaneEnable} <=
                laneEnables(reqPhase || writePhase, readPhase, latchedSize_r); // RULE16 RULE17
        end
    end
    logic [31:0] statusWord, rdMux;
    always_comb begin
        statusWord = mbr_pkg::REG_ZERO;
        statusWord[mbr_pkg::STB_IDLE] = state_r == mbr_pkg::S_IDLE;
        statusWord[mbr_pkg::STB_BEATS_LSB +: 3] = beatsLeft_r;
        statusWord[mbr_pkg::STB_FAULT] = faultSkip;
        statusWord[mbr_pkg::STB_SIZE_LSB +: 2] = latchedSize_r;
        statusWord[mbr_pkg::STB_REJECT] = reject_r;
        statusWord[mbr_pkg::STB_LOADIB] = loadIbSync;
        statusWord[mbr_pkg::STB_GRANT] = grantSync;
        statusWord[mbr_pkg::STB_BUSY] = busySync;
        case (araddr)
            mbr_pkg::OFS_MODE: rdMux = mode_r;
            mbr_pkg::OFS_ADDR: rdMux = addrReg_r;
            mbr_pkg::OFS_WDATA: rdMux = wdataReg_r;
            mbr_pkg::OFS_CMD: rdMux = cmd_r;
            mbr_pkg::OFS_STATUS: rdMux = statusWord;
            mbr_pkg::OFS_WREG5: rdMux = workReg5_r;
            mbr_pkg::OFS_RD_WORK: rdMux = rdWork_r;
            mbr_pkg::OFS_RD_LOCAL: rdMux = rdLocal_r;
            default: rdMux = mbr_pkg::REG_ZERO;
        endcase
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= mbr_pkg::REG_ZERO;
            rresp <= mbr_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rdMux;
            rresp <= isMapped(araddr) ? mbr_pkg::RESP_OKAY : mbr_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_req_holds_grant: assert property (memReq && !grantSync |=> memReq) // RULE10
        else $error("request dropped without grant");
    a_req_type_bit: assert property (memReq |-> reqTypeBit && !dataReq) // RULE4
        else $error("request without type bit");
    a_addr_all_lanes: assert property (memReq |-> {upperHalfEnable, byte1LaneEnable, byte0LaneEnable}
        == mbr_pkg::LANES_ALL) // RULE16
        else $error("address lanes not all enabled");
    a_addr_on_bus: assert property (memReq |-> dataOut == $past(addrReg_r)) // RULE9
        else $error("address not driven");
    a_wreg5_on_grant: assert property (state_r == mbr_pkg::S_REQ_DONE |=> workReg5_r == $past(addrReg_r)
        && latchedSize_r == $past(sizeLines)) // RULE11
        else $error("grant did not store address and size");
    a_gap_after_req: assert property (state_r == mbr_pkg::S_REQ_DONE |=> !dataReq [*4]) // RULE13
        else $error("transfer too soon after request");
    a_stall_on_busy: assert property (dataReq && busySync |=> dataReq && !transferDone) // RULE21
        else $error("transfer ended while busy");
    a_done_after_busy: assert property (transferDone |-> $past(dataReq) && $past(!busySync)
        ##1 !transferDone) // RULE20
        else $error("transfer done without busy release");
    a_byte_read_lanes: assert property (dataReq && cmdRead && latchedSize_r == mbr_pkg::SIZE_BYTE
        |-> {upperHalfEnable, byte1LaneEnable, byte0LaneEnable} == mbr_pkg::LANES_BYTE) // RULE17
        else $error("byte read lanes wrong");
    a_no_quad_write: assert property (dataReq && !cmdRead |-> !quadRef_r
        && cmdDsel == mbr_pkg::DSEL_WRITE) // RULE3
        else $error("quadword write issued");
    a_octa_beats: assert property (state_r == mbr_pkg::S_REQ_DONE && cmdKind == mbr_pkg::KIND_OCTA
        |=> beatsLeft_r == mbr_pkg::BEATS_OCTA) // RULE1
        else $error("octaword not four transfers");
    a_prefetch_no_data: assert property (state_r == mbr_pkg::S_REQ_DONE && cmdKind == mbr_pkg::KIND_PREFETCH
        |=> beatsLeft_r == mbr_pkg::BEATS_NONE) // RULE2
        else $error("prefetch opened data transfers");
    a_fault_skip: assert property (xferEnd && faultSync |=> faultSkip ##1 beatsLeft_r == mbr_pkg::BEATS_NONE) // RULE22
        else $error("fault not offered as skip");
    c_read_virtual: cover property (memReq && funcCode == mbr_pkg::FUNC_READ_VIRT); // RULE5
    c_octa_write: cover property (dataReq && !cmdRead && beatsLeft_r == mbr_pkg::BEATS_OCTA);
    c_fault_seen: cover property (xferEnd && faultSync);
    c_prefetch_ref: cover property (memReq && cmdKind == mbr_pkg::KIND_PREFETCH);
endmodule : mbr_port
`default_nettype wire

// ==== tb/mbr_ctl_model.sv ====
// Behavioural memory controller at the far side of the reference port
`timescale 1ns/1ps
`default_nettype none
module mbr_ctl_model (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic memReq, // Request
    input wire logic dataReq, // Data request
    input wire logic transferDone, // Done
    output logic grant, // Grant
    output logic busy, // Busy
    output logic gateDir, // Direction
    output logic [31:0] data // Read data
);
    logic [3:0] cnt;
    logic dReqQ;
    assign gateDir = !dataReq;
    // Inverted pattern while busy so stale data cannot pass
    assign data = busy ? 32'hFFFF_FF7E : 32'h0000_0081;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            grant <= 1'b0;
            busy <= 1'b0;
            cnt <= 4'h0;
            dReqQ <= 1'b0;
        end else begin
            dReqQ <= dataReq;
            if (memReq && !grant) begin
                grant <= 1'b1;
                busy <= 1'b1;
                cnt <= 4'h4;
            end else if (dataReq && !dReqQ) begin
                busy <= 1'b1;
                cnt <= 4'h3;
            end else if (cnt != 4'h0) cnt <= cnt - 4'h1;
            else if (dataReq) busy <= 1'b0;
            if (transferDone) grant <= 1'b0;
        end
    end
endmodule : mbr_ctl_model
`default_nettype wire

// ==== tb/mbr_port_tb_top.sv ====
// Bench for the memory bus reference port
`timescale 1ns/1ps
`default_nettype none
module mbr_port_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, faultPin = 1'b0;
    logic [31:0] wdata = 32'h0000_0000, rd, rdata, dataIn, dataOut;
    logic awready, wready, bvalid, arready, rvalid, grant, busy, gateDir, memReq, reqTypeBit, dataReq;
    logic transferDone, dataOe_n, legacyModeFlag, upperHalfEnable, byte1LaneEnable, byte0LaneEnable, faultSkip;
    logic [1:0] bresp, rresp, resp, sizeLines, privilegeLevel;
    logic [4:0] funcCode;
    int bad_count = 0, n_compared = 0, cyc = 0, i;
    always #2.5 clk = ~clk;
    mbr_port dut_u (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .grantIn(grant),
        .busyIn(busy), .faultSummaryIn(faultPin), .gateDirIn(gateDir), .loadInstrBufferIn(1'b0), .dataIn, .dataOut,
        .dataOe_n, .memReq, .reqTypeBit, .sizeLines, .funcCode, .legacyModeFlag, .privilegeLevel, .dataReq,
        .transferDone, .upperHalfEnable, .byte1LaneEnable, .byte0LaneEnable, .faultSkip);
    mbr_ctl_model ctl_u (.clk, .rst, .memReq, .dataReq, .transferDone, .grant, .busy, .gateDir, .data(dataIn));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rdw(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : rdw
    task automatic summarize();
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk("idle pins", 32'h0000_0000, {memReq, dataReq, transferDone});
        wr(mbr_pkg::OFS_MODE, 32'h0000_0005);
        wr(mbr_pkg::OFS_ADDR, 32'h1234_5678);
        wr(mbr_pkg::OFS_CMD, 32'h0000_0008);
        for (i = 0; i < 20 && memReq !== 1'b1; i++) @(posedge clk);
        chk("request", 32'h0000_0088, {reqTypeBit, sizeLines, funcCode});
        chk("mode", 32'h0000_0005, {privilegeLevel, legacyModeFlag});
        chk("address", 32'h1234_5678, dataOut);
        chk("addr lanes", 32'h0000_0007, {dataOe_n, upperHalfEnable, byte1LaneEnable, byte0LaneEnable});
        for (i = 0; i < 30 && memReq !== 1'b0; i++) @(posedge clk);
        rdw(mbr_pkg::OFS_WREG5);
        chk("wreg5", 32'h1234_5678, rd);
        wr(mbr_pkg::OFS_CMD, 32'h0000_0208);
        for (i = 0; i < 20 && dataReq !== 1'b1; i++) @(posedge clk);
        chk("read lanes", 32'h0000_0001, {upperHalfEnable, byte1LaneEnable, byte0LaneEnable});
        for (i = 0; i < 40 && transferDone !== 1'b1; i++) @(posedge clk);
        chk("done", 32'h0000_0001, transferDone);
        rdw(mbr_pkg::OFS_RD_WORK);
        chk("sign ext", 32'hFFFF_FF81, rd);
        wr(mbr_pkg::OFS_CMD, 32'h0000_0208);
        rdw(mbr_pkg::OFS_STATUS);
        chk("reject", 32'h0000_0080, rd & 32'h0000_0080);
        faultPin <= 1'b1;
        wr(mbr_pkg::OFS_CMD, 32'h0000_0108);
        for (i = 0; i < 30 && memReq !== 1'b0; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        wr(mbr_pkg::OFS_CMD, 32'h0000_0208);
        for (i = 0; i < 40 && transferDone !== 1'b1; i++) @(posedge clk);
        chk("fault skip", 32'h0000_0001, faultSkip);
        rdw(mbr_pkg::OFS_STATUS);
        chk("fault beats", 32'h0000_0010, rd & 32'h0000_001E);
        rdw(8'h40);
        chk("unmapped", {30'h0, mbr_pkg::RESP_SLVERR}, {30'h0, resp});
        wr(8'h40, 32'h0000_0000);
        chk("unmapped wr", {30'h0, mbr_pkg::RESP_SLVERR}, {30'h0, resp});
        summarize();
    end
endmodule : mbr_port_tb_top
`default_nettype wire
